// >>> hdl/epec_pkg.sv
// Shared constants and types for the EEPROM program/erase command controller.
// Assumes a single 50 MHz bus clock and an AHB-Lite register bus with word-aligned registers.
package epec_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [15:0] EPEC_IDX_FIRST  = 16'h3020;
   localparam logic [15:0] EPEC_IDX_LAST   = 16'h302f;
   localparam logic [15:0] EPEC_IDX_CLKDIV = 16'h3020;
   localparam logic [15:0] EPEC_IDX_SEC    = 16'h3021;
   localparam logic [15:0] EPEC_IDX_PARAM_INDEX = 16'h3022;
   localparam logic [15:0] EPEC_IDX_CFG    = 16'h3024;
   localparam logic [15:0] EPEC_IDX_ERCFG  = 16'h3025;
   localparam logic [15:0] EPEC_IDX_STAT   = 16'h3026;
   localparam logic [15:0] EPEC_IDX_ERSTAT = 16'h3027;
   localparam logic [15:0] EPEC_IDX_FPROT  = 16'h3028;
   localparam logic [15:0] EPEC_IDX_EEPROT = 16'h3029;
   localparam logic [15:0] EPEC_IDX_CCOBHI = 16'h302a;
   localparam logic [15:0] EPEC_IDX_CCOBLO = 16'h302b;
   localparam logic [15:0] EPEC_IDX_FOPT   = 16'h302c;

   // Reset values.
   localparam logic [7:0]  EPEC_RST_CLKDIV = 8'h00;
   localparam logic [7:0]  EPEC_RST_STAT   = 8'h80;
   localparam logic [7:0]  EPEC_RST_REG    = 8'h00;
   localparam logic [15:0] EPEC_RST_CCOB   = 16'h0000;

   // Field positions.
   localparam int EPEC_ST_CMD_COMPLETE_FLAG   = 7;
   localparam int EPEC_ST_ACCESS_ERROR_FLAG = 5;
   localparam int EPEC_ST_PROTECTION_VIOLATION_FLAG = 4;
   localparam int EPEC_CD_LOADED = 7;
   localparam int EPEC_CD_LOCK   = 6;
   localparam int EPEC_PR_ENABLE = 7;

   // Command codes and parameter index values.
   localparam logic [7:0] EPEC_CMD_PROG  = 8'h11;
   localparam logic [7:0] EPEC_CMD_ERASE = 8'h12;
   localparam logic [2:0] EPEC_IX_ADDR   = 3'h1;
   localparam logic [2:0] EPEC_IX_BYTE0  = 3'h2;
   localparam logic [2:0] EPEC_IX_BYTE3  = 3'h5;

   // Timing, counted on the 1 MHz timebase made by the clock divider.
   localparam int EPEC_MCLK_MHZ      = 50;
   localparam int EPEC_TIMEBASE_MHZ  = 1;
   localparam int EPEC_PROG_TIME_US  = 40;
   localparam int EPEC_ERASE_TIME_US = 5000;
   localparam int EPEC_PROG_TICKS    = EPEC_PROG_TIME_US * EPEC_TIMEBASE_MHZ;
   localparam int EPEC_ERASE_TICKS   = EPEC_ERASE_TIME_US * EPEC_TIMEBASE_MHZ;

   // Bus encodings.
   localparam logic [1:0] EPEC_HTRANS_IDLE = 2'h0;
   localparam logic       EPEC_HRESP_OKAY  = 1'b0;

   // Captured AHB address phase.
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [15:0] idx;
   } epec_ap_t;

   // Command sequencer states.
   typedef enum logic [2:0] {
      EPEC_S_IDLE   = 3'b000,
      EPEC_S_WRITE  = 3'b001,
      EPEC_S_WAIT   = 3'b010,
      EPEC_S_VREAD  = 3'b011,
      EPEC_S_VCHECK = 3'b100,
      EPEC_S_DONE   = 3'b101
   } epec_state_t;

endpackage

// >>> hdl/epec_mem.sv
// Byte-wide EEPROM array with one write port and a registered read port.
// Assumes writes and reads come from one sequencer in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module epec_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] cells [2**AW];
   logic [DW-1:0] rdata_ff;

   // The cell array holds no reset, as a real array would not.
   always_ff @(posedge mclk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
   end

   // Read data always appear one edge after the address.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= cells[addr];
      end
   end

   assign rdata = rdata_ff;

endmodule
`default_nettype wire

// >>> hdl/epec_ctrl.sv
// EEPROM program/erase command controller with its register set on AHB-Lite.
// Assumes one master, single word transfers, and a bus clock of 50 MHz.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: Command 0x11 writes one to four erased bytes, then verifies them.
// RULE2: Software puts word address at index 1 and bytes at indices 2 to 5.
// RULE3: Byte count comes from the parameter index value at launch.
// RULE4: Clearing the complete flag launches; program only if unprotected; flag sets when done.
// RULE5: Program launch with index below 2 or above 5 raises access error.
// RULE6: Either command in a forbidden operating mode raises access error.
// RULE7: An invalid 24-bit EEPROM global address raises access error.
// RULE8: Program bytes running past the EEPROM end raise access error.
// RULE9: A protected target area raises the protection-violation flag.
// RULE10: Verify errors set upper status bit; uncorrectable errors set lower bit. The code sets both bits on a verify failure.
// RULE11: Software puts 0x12 at index 0 and sector address at index 1.
// RULE12: Sector erase clears every byte of the sector, verifies, then completes.
// RULE13: Erase launch with index other than 1 raises access error.
// RULE14: Software programs only erased bytes and never adds bits later.
// RULE15: Sixteen register locations span 0x3020 to 0x302F.
// RULE16: Software writes no register while a command runs.
// RULE17: Program and erase timing runs from the clock divider setting.
// RULE18: Software sets the divider field to give a 1 MHz timebase.
// RULE19: Parameter index picks the command word seen through high and low registers.
// RULE20: A launch-time error skips the operation and leaves the complete flag set.
module epec_ctrl #(
   parameter int          EE_SIZE       = 256,
   parameter int          SECT_BYTES    = 4,
   parameter logic [23:0] EE_BASE       = 24'h800000,
   parameter int          PROG_TIME_US  = epec_pkg::EPEC_PROG_TICKS,
   parameter int          ERASE_TIME_US = epec_pkg::EPEC_ERASE_TICKS,
   parameter logic [7:0]  SEC_VALUE     = 8'h02,
   parameter logic [7:0]  FPROT_VALUE   = 8'h00,
   parameter logic [7:0]  FOPT_VALUE    = 8'h00
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        mode_allows_cmd,
   output logic             cmd_busy
);
   import epec_pkg::*;

   localparam int OW        = $clog2(EE_SIZE);
   localparam int TW        = 24;
   localparam int PROT_GRAN = EE_SIZE / 16;

   epec_ap_t      ap_ff;
   epec_state_t   state_ff;
   logic [31:0]   hrdata_ff;
   logic          hreadyout_ff;
   logic          busy_ff;
   logic [7:0]    clkdiv_ff, cfg_ff, ercfg_ff, erstat_ff, eeprot_ff;
   logic [2:0]    ix_ff;
   logic [15:0]   ccob_ff [6];
   logic          cmd_complete_flag_ff, access_error_flag_ff, protection_violation_flag_ff;
   logic [1:0]    mg_ff;
   logic [5:0]    div_cnt_ff;
   logic          tick_ff;
   logic [OW-1:0] base_ff, pos_ff;
   logic [OW:0]   len_ff;
   logic          erase_ff;
   logic [TW-1:0] wait_ff;
   logic [7:0]    rd_byte;
   logic [7:0]    mem_rdata;

   // Address-phase decode; a misaligned or out-of-window address maps to nothing.
   wire logic        take     = hsel & hready & htrans[1];
   wire logic        addr_ok  = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
   wire logic [15:0] addr_idx = addr_ok ? haddr[17:2] : 16'h0000;
   wire logic [2:0]  ix_read  = (ix_ff <= EPEC_IX_BYTE3) ? ix_ff : 3'h0;
   wire logic        ix_live  = (ix_ff <= EPEC_IX_BYTE3);
   wire logic [15:0] ccob_cur = ix_live ? ccob_ff[ix_read] : 16'h0000;

   // Data-phase write strobes; writable registers are frozen while a command runs.
   wire logic       wr_en     = ap_ff.sel & ap_ff.wr & cmd_complete_flag_ff;
   wire logic [7:0] wd        = hwdata[7:0];
   wire logic       wr_clkdiv = wr_en && (ap_ff.idx == EPEC_IDX_CLKDIV);
   wire logic       wr_ix     = wr_en && (ap_ff.idx == EPEC_IDX_PARAM_INDEX);
   wire logic       wr_cfg    = wr_en && (ap_ff.idx == EPEC_IDX_CFG);
   wire logic       wr_ercfg  = wr_en && (ap_ff.idx == EPEC_IDX_ERCFG);
   wire logic       wr_stat   = wr_en && (ap_ff.idx == EPEC_IDX_STAT);
   wire logic       wr_erstat = wr_en && (ap_ff.idx == EPEC_IDX_ERSTAT);
   wire logic       wr_eeprot = wr_en && (ap_ff.idx == EPEC_IDX_EEPROT);
   wire logic       wr_hi     = wr_en && (ap_ff.idx == EPEC_IDX_CCOBHI) && ix_live;
   wire logic       wr_lo     = wr_en && (ap_ff.idx == EPEC_IDX_CCOBLO) && ix_live;

   // Command decode and launch-time checks on the command object.
   wire logic [7:0]  cmd_code = ccob_ff[0][15:8];
   wire logic [23:0] gaddr    = {ccob_ff[0][7:0], ccob_ff[1]};
   wire logic [23:0] off_full = gaddr - EE_BASE;
   wire logic        is_prog  = (cmd_code == EPEC_CMD_PROG);
   wire logic        is_erase = (cmd_code == EPEC_CMD_ERASE);
   wire logic [2:0]  nbytes   = ix_ff - EPEC_IX_ADDR;
   wire logic        launch   = wr_stat & wd[EPEC_ST_CMD_COMPLETE_FLAG];
   wire logic        ix_bad   = is_prog ? ((ix_ff < EPEC_IX_BYTE0) || (ix_ff > EPEC_IX_BYTE3))
                                        : (ix_ff != EPEC_IX_ADDR);
   wire logic        in_range = (gaddr >= EE_BASE) && (off_full < 24'(EE_SIZE));
   wire logic [24:0] prog_end = {1'b0, off_full} + {22'h000000, nbytes};
   wire logic        breach   = is_prog && (prog_end > 25'(EE_SIZE));
   wire logic [OW-1:0] off      = off_full[OW-1:0];
   wire logic [OW-1:0] sect_off = off & ~OW'(SECT_BYTES - 1);
   wire logic [OW:0]   end_off  = is_erase ? ({1'b0, sect_off} + (OW+1)'(SECT_BYTES - 1))
                                           : ({1'b0, off} + {{(OW-2){1'b0}}, nbytes} - 1'b1);
   wire logic [OW:0]   prot_bnd = (OW+1)'(int'(eeprot_ff[3:0]) * PROT_GRAN);
   wire logic          prot_hit = eeprot_ff[EPEC_PR_ENABLE] && (end_off >= prot_bnd);
   wire logic acc_err = launch & (!(is_prog | is_erase) | ix_bad | !mode_allows_cmd // RULE5 RULE13
                                  | !in_range | breach); // RULE6 RULE7 RULE8
   wire logic pv_err  = launch & !acc_err & prot_hit; // RULE9
   wire logic go      = launch & !acc_err & !pv_err; // RULE4 RULE20

   // Sequencer datapath: array address, expected byte and verify compare.
   wire logic [2:0] byte_ix   = 3'(pos_ff[1:0]) + EPEC_IX_BYTE0;
   wire logic [7:0] expected  = erase_ff ? 8'hff : ccob_ff[byte_ix][7:0]; // RULE12 RULE1
   wire logic [OW-1:0] mem_addr = base_ff + pos_ff;
   wire logic       mem_we    = (state_ff == EPEC_S_WRITE);
   wire logic       last_pos  = ({1'b0, pos_ff} == (len_ff - 1'b1));
   wire logic       vfail     = (state_ff == EPEC_S_VCHECK) && (mem_rdata != expected);

   // Read multiplexer for the sixteen-location register window.
   always_comb begin
      case (addr_idx)
         EPEC_IDX_CLKDIV: rd_byte = clkdiv_ff;
         EPEC_IDX_SEC:    rd_byte = SEC_VALUE;
         EPEC_IDX_PARAM_INDEX: rd_byte = {5'h00, ix_ff};
         EPEC_IDX_CFG:    rd_byte = cfg_ff;
         EPEC_IDX_ERCFG:  rd_byte = ercfg_ff;
         EPEC_IDX_STAT:   rd_byte = {cmd_complete_flag_ff, 1'b0, access_error_flag_ff, protection_violation_flag_ff, 2'b00, mg_ff};
         EPEC_IDX_ERSTAT: rd_byte = erstat_ff;
         EPEC_IDX_FPROT:  rd_byte = FPROT_VALUE;
         EPEC_IDX_EEPROT: rd_byte = eeprot_ff;
         EPEC_IDX_CCOBHI: rd_byte = ccob_cur[15:8]; // RULE19
         EPEC_IDX_CCOBLO: rd_byte = ccob_cur[7:0]; // RULE19
         EPEC_IDX_FOPT:   rd_byte = FOPT_VALUE;
         default:         rd_byte = 8'h00; // RULE15
      endcase
   end

   // Bus slave: zero wait states, read data registered for the data phase.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ap_ff        <= '0;
         hrdata_ff    <= 32'h00000000;
         hreadyout_ff <= 1'b0;
      end else begin
         ap_ff        <= '{sel: take, wr: hwrite, idx: addr_idx};
         hrdata_ff    <= (take && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
         hreadyout_ff <= 1'b1;
      end
   end

   // Plain software registers and the clock divider with its lock.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         clkdiv_ff <= EPEC_RST_CLKDIV;
         ix_ff     <= 3'h0;
         cfg_ff    <= EPEC_RST_REG;
         ercfg_ff  <= EPEC_RST_REG;
         erstat_ff <= EPEC_RST_REG;
         eeprot_ff <= EPEC_RST_REG;
      end else begin
         if (wr_clkdiv) begin
            clkdiv_ff[EPEC_CD_LOADED] <= 1'b1;
            clkdiv_ff[EPEC_CD_LOCK]   <= clkdiv_ff[EPEC_CD_LOCK] | wd[EPEC_CD_LOCK];
            if (!clkdiv_ff[EPEC_CD_LOCK]) begin
               clkdiv_ff[5:0] <= wd[5:0];
            end
         end
         if (wr_ix) begin
            ix_ff <= wd[2:0];
         end
         if (wr_cfg) begin
            cfg_ff <= wd;
         end
         if (wr_ercfg) begin
            ercfg_ff <= wd;
         end
         if (wr_erstat) begin
            erstat_ff <= erstat_ff & ~wd;
         end
         if (wr_eeprot) begin
            eeprot_ff <= wd;
         end
      end
   end

   // Command object array, one word per index, written byte-wise.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 6; i++) begin
            ccob_ff[i] <= EPEC_RST_CCOB;
         end
      end else begin
         if (wr_hi) begin
            ccob_ff[ix_read][15:8] <= wd; // RULE19
         end
         if (wr_lo) begin
            ccob_ff[ix_read][7:0] <= wd; // RULE19
         end
      end
   end

   // Status flags; a hardware set wins over a software clear in the same cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmd_complete_flag_ff   <= EPEC_RST_STAT[EPEC_ST_CMD_COMPLETE_FLAG];
         access_error_flag_ff <= 1'b0;
         protection_violation_flag_ff <= 1'b0;
         mg_ff     <= 2'b00;
         busy_ff   <= 1'b0;
      end else begin
         cmd_complete_flag_ff   <= go ? 1'b0 : (cmd_complete_flag_ff | (state_ff == EPEC_S_DONE)); // RULE4 RULE12
         access_error_flag_ff <= acc_err | (access_error_flag_ff & ~(wr_stat & wd[EPEC_ST_ACCESS_ERROR_FLAG]));
         protection_violation_flag_ff <= pv_err | (protection_violation_flag_ff & ~(wr_stat & wd[EPEC_ST_PROTECTION_VIOLATION_FLAG]));
         mg_ff     <= go ? 2'b00 : (mg_ff | {vfail, vfail}); // RULE10
         busy_ff   <= go | (busy_ff & (state_ff != EPEC_S_DONE));
      end
   end

   // Timebase: one tick every divider_field+1 bus clocks.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_ff <= 6'h00;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff    <= (div_cnt_ff == clkdiv_ff[5:0]); // RULE17
         div_cnt_ff <= (div_cnt_ff == clkdiv_ff[5:0]) ? 6'h00 : div_cnt_ff + 6'h01;
      end
   end

   // Sequencer: write every byte, wait the timed interval, then read back and compare.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= EPEC_S_IDLE;
         base_ff  <= '0;
         pos_ff   <= '0;
         len_ff   <= '0;
         erase_ff <= 1'b0;
         wait_ff  <= '0;
      end else begin
         case (state_ff)
            EPEC_S_IDLE: begin
               if (go) begin
                  state_ff <= EPEC_S_WRITE;
                  erase_ff <= is_erase;
                  base_ff  <= is_erase ? sect_off : off; // RULE12
                  len_ff   <= is_erase ? (OW+1)'(SECT_BYTES) : (OW+1)'(nbytes); // RULE3
                  pos_ff   <= '0;
               end
            end
            EPEC_S_WRITE: begin
               if (last_pos) begin
                  state_ff <= EPEC_S_WAIT;
                  pos_ff   <= '0;
                  wait_ff  <= erase_ff ? TW'(ERASE_TIME_US) : TW'(PROG_TIME_US); // RULE17
               end else begin
                  pos_ff <= pos_ff + 1'b1;
               end
            end
            EPEC_S_WAIT: begin
               if (wait_ff == '0) begin
                  state_ff <= EPEC_S_VREAD;
               end else if (tick_ff) begin
                  wait_ff <= wait_ff - 1'b1;
               end
            end
            EPEC_S_VREAD: begin
               state_ff <= EPEC_S_VCHECK;
            end
            EPEC_S_VCHECK: begin
               if (last_pos) begin
                  state_ff <= EPEC_S_DONE; // RULE1
               end else begin
                  pos_ff   <= pos_ff + 1'b1;
                  state_ff <= EPEC_S_VREAD;
               end
            end
            EPEC_S_DONE: begin
               state_ff <= EPEC_S_IDLE;
            end
            default: begin
               state_ff <= EPEC_S_IDLE;
            end
         endcase
      end
   end

   // EEPROM cell array with registered read data.
   epec_mem #(
      .AW (OW),
      .DW (8)
   ) u_mem (
      .mclk  (mclk),
      .nrst  (nrst),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (expected),
      .rdata (mem_rdata)
   );

   // Output drivers, straight from flip-flops except hresp, which is tied to OKAY.
   assign hreadyout = hreadyout_ff;
   assign hresp     = EPEC_HRESP_OKAY;
   assign hrdata    = hrdata_ff;
   assign cmd_busy  = busy_ff;

   // Checks of the command flow.
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_launch_ok;
      go ##1 ((state_ff == EPEC_S_WRITE) && !cmd_complete_flag_ff);
   endsequence
   sequence s_verify_step;
      (state_ff == EPEC_S_VREAD) ##1 (state_ff == EPEC_S_VCHECK);
   endsequence

   a_launch_starts: assert property (go |-> s_launch_ok) // RULE4
      else $error("launch did not clear the complete flag");
   a_prog_index: assert property (launch && is_prog && ix_bad |=> access_error_flag_ff && cmd_complete_flag_ff) // RULE5
      else $error("bad program index not flagged");
   a_erase_index: assert property (launch && is_erase && ix_bad |=> access_error_flag_ff) // RULE13
      else $error("bad erase index not flagged");
   a_mode_check: assert property (launch && !mode_allows_cmd |=> access_error_flag_ff) // RULE6
      else $error("forbidden mode not flagged");
   a_range_check: assert property (launch && (!in_range || breach) |=> access_error_flag_ff) // RULE7 RULE8
      else $error("address range error not flagged");
   a_prot_flag: assert property (pv_err |=> protection_violation_flag_ff && cmd_complete_flag_ff) // RULE9
      else $error("protection violation not flagged");
   a_error_no_op: assert property (launch && !go |=> (state_ff == EPEC_S_IDLE) [*2]) // RULE20
      else $error("failed launch started an operation");
   a_byte_count: assert property (go && is_prog |=> len_ff == (OW+1)'($past(nbytes))) // RULE3
      else $error("byte count not taken from index");
   a_verify_flag: assert property (vfail |=> mg_ff == 2'b11) // RULE10
      else $error("verify failure not reported");
   a_verify_walk: assert property ((state_ff == EPEC_S_VREAD) |-> s_verify_step) // RULE12
      else $error("verify read not followed by compare");
   a_done_flag: assert property ((state_ff == EPEC_S_DONE) |=> cmd_complete_flag_ff && !busy_ff) // RULE1
      else $error("complete flag not set at the end");
   a_wait_hold: assert property ((state_ff == EPEC_S_WAIT) && (wait_ff != '0) && !tick_ff
                                 |=> $stable(wait_ff)) // RULE17
      else $error("timer moved without a timebase tick");
   a_ccob_read: assert property (take && !hwrite && (addr_idx == EPEC_IDX_CCOBHI)
                                 |=> hrdata_ff[7:0] == $past(ccob_cur[15:8])) // RULE19
      else $error("indexed read returned wrong word");

endmodule
`default_nettype wire

// >>> testbench/tb_eeprom_program_erase_cmd.sv
// Self-checking testbench for the EEPROM program/erase command controller.
// Assumes the controller answers on AHB-Lite with zero wait states and a divider of 0.
`timescale 1ns/10ps
`default_nettype none
module tb_eeprom_program_erase_cmd;
   import epec_pkg::*;
   // One command case: code, address, index at launch, mode, protection, status after launch.
   typedef struct packed {
      logic [7:0]  code;
      logic [7:0]  ahi;
      logic [15:0] alo;
      logic [2:0]  ix;
      logic        mode;
      logic [7:0]  prot;
      logic [7:0]  st;
   } epec_case_t;
   localparam epec_case_t CASES [13] = '{
      '{8'h12, 8'h80, 16'h0009, 3'h1, 1'b1, 8'h00, 8'h00},
      '{8'h12, 8'h80, 16'h00fd, 3'h1, 1'b1, 8'h00, 8'h00},
      '{8'h11, 8'h80, 16'h0008, 3'h5, 1'b1, 8'h00, 8'h00},
      '{8'h11, 8'h80, 16'h00ff, 3'h2, 1'b1, 8'h00, 8'h00},
      '{8'h11, 8'h80, 16'h0008, 3'h1, 1'b1, 8'h00, 8'ha0},
      '{8'h11, 8'h80, 16'h0008, 3'h6, 1'b1, 8'h00, 8'ha0},
      '{8'h12, 8'h80, 16'h0008, 3'h2, 1'b1, 8'h00, 8'ha0},
      '{8'h11, 8'h80, 16'h0008, 3'h2, 1'b0, 8'h00, 8'ha0},
      '{8'h12, 8'h80, 16'h0008, 3'h1, 1'b0, 8'h00, 8'ha0},
      '{8'h11, 8'h81, 16'h0008, 3'h2, 1'b1, 8'h00, 8'ha0},
      '{8'h11, 8'h80, 16'h00fe, 3'h5, 1'b1, 8'h00, 8'ha0},
      '{8'h11, 8'h80, 16'h00f0, 3'h2, 1'b1, 8'h8f, 8'h90},
      '{8'h13, 8'h80, 16'h0008, 3'h1, 1'b1, 8'h00, 8'ha0}
   };
   localparam logic [15:0] RIDX [11] = '{EPEC_IDX_CLKDIV, EPEC_IDX_SEC, EPEC_IDX_PARAM_INDEX,
      EPEC_IDX_CFG, EPEC_IDX_ERCFG, EPEC_IDX_STAT, EPEC_IDX_ERSTAT, EPEC_IDX_FPROT,
      EPEC_IDX_CCOBHI, 16'h3023, 16'h302f};
   localparam logic [7:0]  RVAL [11] = '{8'h00, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
      8'h3c, 8'h00, 8'h00, 8'h00};
   logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, mode_allows_cmd, cmd_busy, ap_rd;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  exp_q [$];
   logic [7:0]  dat [4];
   epec_case_t  c;
   int          num_errors, compares, cyc;

   // Short timing values keep each command within a few dozen clocks.
   epec_ctrl #(
      .PROG_TIME_US  (10),
      .ERASE_TIME_US (20),
      .SEC_VALUE     (8'h5a),  // Arbitrary value.
      .FPROT_VALUE   (8'h3c),  // Arbitrary value.
      .FOPT_VALUE    (8'hc3)   // Arbitrary value.
   ) dut (
      .mclk            (mclk),
      .nrst            (nrst),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hreadyout),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .mode_allows_cmd (mode_allows_cmd),
      .cmd_busy        (cmd_busy)
   );

   // The clock toggles every half period of 10 ns.
   always #10 mclk = ~mclk;

   // Counts one comparison (read data, hresp or cmd_busy) and prints it if it mismatches.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Comparisons: %0d, errors: %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One single AHB-Lite transfer, holding each phase until hready is seen high.
   task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] d);
      @(posedge mclk);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {14'h0, idx, 2'h0};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      htrans <= EPEC_HTRANS_IDLE;
      hwdata <= {24'h0, d};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
   endtask

   // A write, and a read whose expected byte is noted for the monitor.
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      bus(idx, 1'b0, 8'h00);
   endtask

   // Marks a read address phase, then checks its data at the edge that ends the data phase.
   always @(posedge mclk) begin
      if (ap_rd === 1'b1) begin
         chk(hrdata, {24'h0, exp_q.pop_front()});
         chk({31'h0, hresp}, {31'h0, EPEC_HRESP_OKAY});
      end
      ap_rd <= nrst & hsel & htrans[1] & ~hwrite & hreadyout;
   end

   // Cuts a hang short.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         complete_run();
      end
   end

   // Main sequence: reset values, register access, then every command case.
   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      htrans = '0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      mode_allows_cmd = 1'b1;
      num_errors = 0;
      compares = 0;
      cyc = 0;
      void'($urandom(65339));
      foreach (dat[j]) dat[j] = 8'($urandom());
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      hsel <= 1'b1;
      for (int i = 0; i < 11; i++) rd(RIDX[i], RVAL[i]);
      wr(EPEC_IDX_SEC, 8'hff);
      rd(EPEC_IDX_SEC, 8'h5a);
      wr(EPEC_IDX_CLKDIV, 8'h00);
      rd(EPEC_IDX_CLKDIV, 8'h80);
      for (int j = 0; j < 4; j++) begin
         wr(EPEC_IDX_PARAM_INDEX, 8'(j + 2));
         wr(EPEC_IDX_CCOBLO, dat[j]);
      end
      wr(EPEC_IDX_PARAM_INDEX, 8'h03);
      rd(EPEC_IDX_CCOBLO, dat[1]);
      for (int i = 0; i < 13; i++) begin
         c = CASES[i];
         mode_allows_cmd <= c.mode;
         wr(EPEC_IDX_EEPROT, c.prot);
         wr(EPEC_IDX_PARAM_INDEX, 8'h00);
         wr(EPEC_IDX_CCOBHI, c.code);
         wr(EPEC_IDX_CCOBLO, c.ahi);
         wr(EPEC_IDX_PARAM_INDEX, 8'h01);
         wr(EPEC_IDX_CCOBHI, c.alo[15:8]);
         wr(EPEC_IDX_CCOBLO, c.alo[7:0]);
         wr(EPEC_IDX_PARAM_INDEX, {5'h0, c.ix});
         wr(EPEC_IDX_STAT, 8'h80);
         rd(EPEC_IDX_STAT, c.st);
         @(negedge mclk);
         chk({31'h0, cmd_busy}, {31'h0, c.st == 8'h00});
         if (c.st == 8'h00) begin
            wr(EPEC_IDX_ERCFG, 8'h55);
            while (cmd_busy !== 1'b0) @(posedge mclk);
            rd(EPEC_IDX_ERCFG, 8'h00);
            rd(EPEC_IDX_STAT, 8'h80);
         end else begin
            wr(EPEC_IDX_STAT, 8'h30);
            rd(EPEC_IDX_STAT, 8'h80);
         end
      end
      repeat (4) @(posedge mclk);
      complete_run();
   end
endmodule
`default_nettype wire
